// >>> hdl/wake_irq_power_sync_pkg.sv
// Purpose: shared constants for the wake, interrupt and power-sync block
// Assumes: 100 MHz reference clock
// Notes: times are in ns, cycle counts are derived from them
package wake_irq_power_sync_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_FILT_NS = 70000;
  localparam int unsigned IRQ_PULSE_NS = 100000;
  localparam int unsigned SYNC_FILT_NS = 10000;
  localparam int unsigned OFF_DLY_SHORT_NS = 250000;
  localparam int unsigned OFF_DLY_LONG_NS = 32000000;
  localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_FILT_CYC = (SYNC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_DLY_SHORT_CYC = (OFF_DLY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_DLY_LONG_CYC = (OFF_DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAIN_IRQ_W = 23;
  localparam int unsigned FS_IRQ_W = 6;
  localparam int unsigned MAIN_WAKE_INPUT_ONE_BIT = 20;
  localparam int unsigned MAIN_WAKE_INPUT_TWO_BIT = 21;
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] CFG_OFS = 32'h0000_0004;
  localparam logic [31:0] MASK_MAIN_OFS = 32'h0000_0008;
  localparam logic [31:0] MASK_FS_OFS = 32'h0000_000c;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0010;
  localparam int unsigned CTRL_PD_REQ_BIT = 0;
  localparam int unsigned CFG_SYNC_EN_BIT = 0;
  localparam int unsigned CFG_PARTNER_SEL_BIT = 1;
  localparam int unsigned CFG_OFF_DLY_SEL_BIT = 2;
  localparam int unsigned ST_WAKE_LSB = 0;
  localparam int unsigned ST_BIAS_BIT = 2;
  localparam int unsigned ST_PREREG_BIT = 3;
  localparam int unsigned ST_SYNC_BIT = 4;
  localparam int unsigned ST_IRQ_BIT = 5;
  localparam int unsigned ST_PEND_BIT = 6;
  localparam int unsigned ST_STATE_LSB = 8;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [MAIN_IRQ_W-1:0] MASK_MAIN_RST = 23'h00_0000;
  localparam logic [FS_IRQ_W-1:0] MASK_FS_RST = 6'h00;
  typedef enum logic [2:0] {
    SEQ_STANDBY, SEQ_PRE_SYNC, SEQ_PREREG_UP, SEQ_POST_SYNC, SEQ_RUN, SEQ_PD_PARTNER, SEQ_PD_DELAY
  } seq_state_t;
endpackage

// >>> hdl/level_filter.sv
// Purpose: synchronise a pin and accept a new level only after it stays put
// Assumes: raw_i is asynchronous to ref_clk_i
// Notes: three flops; the level counts once the second and third agree
`timescale 1ns/1ns
`default_nettype none
module level_filter #(
  parameter int unsigned CYC = 1000
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic level_o
);
  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic [CW-1:0] cnt_r;

  // synchroniser chain
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= raw_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end

  // stability counter, restarts on any disagreement
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_r <= '0;
      level_o <= 1'b0;
    end
    else if (s2_r == s3_r && s3_r != level_o)
    begin
      if (cnt_r == LAST)
      begin
        level_o <= s3_r;
        cnt_r <= '0;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
    else
      cnt_r <= '0;
endmodule
`default_nettype wire

// >>> hdl/interval_timer.sv
// Purpose: one-shot timer, busy for exactly len_i cycles after a load
// Assumes: len_i is at least one
// Notes: a load while busy restarts the interval
`timescale 1ns/1ns
`default_nettype none
module interval_timer #(
  parameter int unsigned W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] len_i,
  output logic busy_o
);
  logic [W-1:0] cnt_r;

  // count down to zero then drop busy
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_r <= '0;
      busy_o <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_r <= len_i - 1'b1;
      busy_o <= 1'b1;
    end
    else if (busy_o)
    begin
      if (cnt_r == '0)
        busy_o <= 1'b0;
      else
        cnt_r <= cnt_r - 1'b1;
    end
endmodule
`default_nettype wire

// >>> hdl/wake_irq_power_sync.sv
// Purpose: wake filtering, bias control, interrupt pulse and power-sync sequencer
// Assumes: fault events are one-cycle pulses on ref_clk_i; pins are asynchronous
// Notes: registers over AHB-Lite, zero wait states, always OKAY
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module wake_irq_power_sync
  import wake_irq_power_sync_pkg::*;
#(
  parameter int unsigned WAKE_FILT = wake_irq_power_sync_pkg::WAKE_FILT_CYC,
  parameter int unsigned IRQ_PULSE = wake_irq_power_sync_pkg::IRQ_PULSE_CYC,
  parameter int unsigned SYNC_FILT = wake_irq_power_sync_pkg::SYNC_FILT_CYC,
  parameter int unsigned OFF_SHORT = wake_irq_power_sync_pkg::OFF_DLY_SHORT_CYC,
  parameter int unsigned OFF_LONG = wake_irq_power_sync_pkg::OFF_DLY_LONG_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic wake_input_one_i,
  input wire logic wake_input_two_i,
  input wire logic [wake_irq_power_sync_pkg::MAIN_IRQ_W-1:0] main_event_i,
  input wire logic [wake_irq_power_sync_pkg::FS_IRQ_W-1:0] fs_event_i,
  output logic irq_pulse_out_o,
  output logic irq_pulse_out_oe_o,
  input wire logic power_sync_line_i,
  output logic power_sync_line_o,
  output logic power_sync_line_oe_o,
  output logic internal_bias_supply_en_o,
  output logic pre_regulator_en_o,
  output logic power_up_done_o
);
  import wake_irq_power_sync_pkg::*;

  localparam int unsigned IW = $clog2(IRQ_PULSE + 1);
  localparam int unsigned OW = $clog2(OFF_LONG + 1);
  localparam logic [IW-1:0] IRQ_LEN = IW'(IRQ_PULSE);
  localparam logic [OW-1:0] OFF_SHORT_LEN = OW'(OFF_SHORT);
  localparam logic [OW-1:0] OFF_LONG_LEN = OW'(OFF_LONG);

  logic [1:0] wake_lvl;
  logic [1:0] wake_lvl_q_r;
  logic sync_lvl;
  logic pd_req_r;
  logic sync_function_enable_r;
  logic sync_partner_select_r;
  logic prereg_off_delay_select_r;
  logic [MAIN_IRQ_W-1:0] mask_main_r;
  logic [FS_IRQ_W-1:0] mask_fs_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic rd_req;
  logic [31:0] rd_mux;
  logic [31:0] status;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic off_load;
  logic off_busy;
  logic [OW-1:0] off_len;
  logic [MAIN_IRQ_W-1:0] main_evt;
  logic new_evt;
  logic irq_busy;
  logic irq_gap_r;
  logic irq_pend_r;
  logic irq_fire;
  logic bias_r;
  logic prereg_r;
  logic sync_drive_r;
  logic identical_mode;
  logic external_mode;

  // filtered wake levels; sampling threshold decided by the analog front end
  level_filter #(.CYC(WAKE_FILT)) u_wake_one (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .raw_i(wake_input_one_i),
    .level_o(wake_lvl[0])
  );

  level_filter #(.CYC(WAKE_FILT)) u_wake_two (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .raw_i(wake_input_two_i),
    .level_o(wake_lvl[1])
  );

  // sync line feedback filter
  level_filter #(.CYC(SYNC_FILT)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .raw_i(power_sync_line_i),
    .level_o(sync_lvl)
  );

  assign identical_mode = sync_function_enable_r & ~sync_partner_select_r;
  assign external_mode = sync_function_enable_r & sync_partner_select_r;

  // bus: address phase taken when selected and hready high
  assign rd_req = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;

  // write address capture for the following data phase
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
    end
    else if (hready_i)
    begin
      wr_pend_r <= hsel_i & htrans_i[1] & hwrite_i;
      wr_addr_r <= haddr_i;
    end

  // writable registers, written in the data phase
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      pd_req_r <= CTRL_RST;
      sync_function_enable_r <= CFG_RST[CFG_SYNC_EN_BIT];
      sync_partner_select_r <= CFG_RST[CFG_PARTNER_SEL_BIT];
      prereg_off_delay_select_r <= CFG_RST[CFG_OFF_DLY_SEL_BIT];
      mask_main_r <= MASK_MAIN_RST;
      mask_fs_r <= MASK_FS_RST;
    end
    else if (wr_pend_r)
    begin
      case (wr_addr_r)
        CTRL_OFS: pd_req_r <= hwdata_i[CTRL_PD_REQ_BIT];
        CFG_OFS:
        begin
          sync_function_enable_r <= hwdata_i[CFG_SYNC_EN_BIT];
          sync_partner_select_r <= hwdata_i[CFG_PARTNER_SEL_BIT];
          prereg_off_delay_select_r <= hwdata_i[CFG_OFF_DLY_SEL_BIT];
        end
        MASK_MAIN_OFS: mask_main_r <= hwdata_i[MAIN_IRQ_W-1:0];
        MASK_FS_OFS: mask_fs_r <= hwdata_i[FS_IRQ_W-1:0];
        default: ;
      endcase
    end

  // live state seen by software
  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_WAKE_LSB +: 2] = wake_lvl;
    status[ST_BIAS_BIT] = bias_r;
    status[ST_PREREG_BIT] = prereg_r;
    status[ST_SYNC_BIT] = sync_lvl;
    status[ST_IRQ_BIT] = irq_busy;
    status[ST_PEND_BIT] = irq_pend_r;
    status[ST_STATE_LSB +: 3] = state_r;
  end

  // read mux, unmapped reads as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr_i)
      CTRL_OFS: rd_mux[CTRL_PD_REQ_BIT] = pd_req_r;
      CFG_OFS:
      begin
        rd_mux[CFG_SYNC_EN_BIT] = sync_function_enable_r;
        rd_mux[CFG_PARTNER_SEL_BIT] = sync_partner_select_r;
        rd_mux[CFG_OFF_DLY_SEL_BIT] = prereg_off_delay_select_r;
      end
      MASK_MAIN_OFS: rd_mux[MAIN_IRQ_W-1:0] = mask_main_r;
      MASK_FS_OFS: rd_mux[FS_IRQ_W-1:0] = mask_fs_r;
      STATUS_OFS: rd_mux = status;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase edge, no wait states
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hrdata_o <= rd_req ? rd_mux : 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end

  // previous wake levels for transition events
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      wake_lvl_q_r <= 2'h0;
    else
      wake_lvl_q_r <= wake_lvl;

  // main sources: external faults plus wake transitions
  always_comb
  begin
    main_evt = main_event_i;
    main_evt[MAIN_WAKE_INPUT_ONE_BIT] = main_event_i[MAIN_WAKE_INPUT_ONE_BIT] | (wake_lvl[0] ^ wake_lvl_q_r[0]);
    main_evt[MAIN_WAKE_INPUT_TWO_BIT] = main_event_i[MAIN_WAKE_INPUT_TWO_BIT] | (wake_lvl[1] ^ wake_lvl_q_r[1]);
  end

  // a set inhibit bit hides its source
  assign new_evt = (|(main_evt & ~mask_main_r)) | (|(fs_event_i & ~mask_fs_r));
  assign irq_fire = (irq_pend_r | new_evt) & ~irq_busy & ~irq_gap_r;

  // events during a pulse wait for the next one; consumption beats arrival
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      irq_pend_r <= 1'b0;
    else
      irq_pend_r <= (irq_pend_r | new_evt) & ~irq_fire;

  // two idle cycles between pulses so back to back pulses stay distinct
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      irq_gap_r <= 1'b0;
    else
      irq_gap_r <= irq_busy & ~irq_fire;

  // pulse length timer
  interval_timer #(.W(IW)) u_irq_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(irq_fire),
    .len_i(IRQ_LEN),
    .busy_o(irq_busy)
  );

  // open-drain interrupt: data is always low, only the enable moves
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      irq_pulse_out_o <= 1'b0;
    else
      irq_pulse_out_o <= 1'b0;

  // enable is the timer's busy flop: rises at the firing edge, lasts IRQ_PULSE cycles
  assign irq_pulse_out_oe_o = irq_busy;

  // internal biasing
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      bias_r <= 1'b0;
    else if (|wake_lvl)
      bias_r <= 1'b1;
    else if (state_r == SEQ_STANDBY)
      bias_r <= 1'b0;

  // turn-off delay length from the select bit
  assign off_len = prereg_off_delay_select_r ? OFF_LONG_LEN : OFF_SHORT_LEN;

  // power sequencer
  always_comb
  begin
    state_nxt = state_r;
    off_load = 1'b0;
    case (state_r)
      SEQ_STANDBY:
        if (bias_r && (|wake_lvl) && !pd_req_r)
          state_nxt = identical_mode ? SEQ_PRE_SYNC : SEQ_PREREG_UP;
      SEQ_PRE_SYNC:
        if (sync_lvl)
          state_nxt = SEQ_PREREG_UP;
      SEQ_PREREG_UP:
        state_nxt = external_mode ? SEQ_POST_SYNC : SEQ_RUN;
      SEQ_POST_SYNC:
        if (sync_lvl)
          state_nxt = SEQ_RUN;
      SEQ_RUN:
        if (!(|wake_lvl) || pd_req_r)
        begin
          if (external_mode)
            state_nxt = SEQ_PD_PARTNER;
          else
          begin
            state_nxt = SEQ_PD_DELAY;
            off_load = 1'b1;
          end
        end
      SEQ_PD_PARTNER:
        if (!sync_lvl)
        begin
          state_nxt = SEQ_PD_DELAY;
          off_load = 1'b1;
        end
      SEQ_PD_DELAY:
        if (!off_busy)
          state_nxt = SEQ_STANDBY;
      default: state_nxt = SEQ_STANDBY;
    endcase
  end

  // sequencer state
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      state_r <= SEQ_STANDBY;
    else
      state_r <= state_nxt;

  // pre-regulator turn-off timer
  interval_timer #(.W(OW)) u_off_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(off_load),
    .len_i(off_len),
    .busy_o(off_busy)
  );

  // pre-regulator enable follows the sequencer
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      prereg_r <= 1'b0;
    else if (state_nxt == SEQ_PREREG_UP)
      prereg_r <= 1'b1;
    else if (state_nxt == SEQ_STANDBY)
      prereg_r <= 1'b0;

  // identical partner: hold the shared line low until ready to start
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      sync_drive_r <= 1'b0;
    else
      sync_drive_r <= identical_mode && (state_nxt == SEQ_STANDBY || state_nxt == SEQ_PD_DELAY);

  // registered pins and status outputs
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      power_sync_line_o <= 1'b0;
      power_sync_line_oe_o <= 1'b0;
      internal_bias_supply_en_o <= 1'b0;
      pre_regulator_en_o <= 1'b0;
      power_up_done_o <= 1'b0;
    end
    else
    begin
      power_sync_line_o <= 1'b0;
      power_sync_line_oe_o <= sync_drive_r;
      internal_bias_supply_en_o <= bias_r;
      pre_regulator_en_o <= prereg_r;
      power_up_done_o <= (state_r == SEQ_RUN);
    end
endmodule
`default_nettype wire

// >>> tb/wake_irq_power_sync_assertions.sv
// Purpose: port checks for the wake, interrupt and sync block
// Assumes: counts match the instance parameters
// Notes: run-length counters feed the timing checks
`timescale 1ns/1ns
`default_nettype none
module wips_checker #(
  parameter int unsigned WAKE_FILT = 20,
  parameter int unsigned IRQ_PULSE = 30
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wake_input_one_i,
  input wire logic wake_input_two_i,
  input wire logic irq_pulse_out_o,
  input wire logic irq_pulse_out_oe_o,
  input wire logic power_sync_line_o,
  input wire logic internal_bias_supply_en_o,
  input wire logic pre_regulator_en_o,
  input wire logic power_up_done_o
);
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [15:0] irq_r;
  logic any_w;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // run lengths: some wake pin high, both pins low, pulse active
  assign any_w = wake_input_one_i | wake_input_two_i;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
      irq_r <= 16'h0000;
    end
    else
    begin
      hi_r <= any_w ? hi_r + {15'h0000, ~&hi_r} : 16'h0000;
      lo_r <= any_w ? 16'h0000 : lo_r + {15'h0000, ~&lo_r};
      irq_r <= irq_pulse_out_oe_o ? irq_r + 16'h0001 : 16'h0000;
    end
  end
  a_irq_pulse_len: assert property ($fell(irq_pulse_out_oe_o) |-> irq_r == IRQ_PULSE)
    else $error("interrupt pulse length wrong");
  a_irq_pulse_max: assert property (irq_pulse_out_oe_o |-> irq_r < IRQ_PULSE)
    else $error("interrupt pulse too long");
  a_irq_pin_low: assert property (irq_pulse_out_o == 1'b0)
    else $error("interrupt pin driven high");
  a_sync_pin_low: assert property (power_sync_line_o == 1'b0)
    else $error("sync line driven high");
  a_bias_wake_filt: assert property ($rose(internal_bias_supply_en_o) |-> hi_r >= WAKE_FILT)
    else $error("bias started before wake filter time");
  a_bias_off_filt: assert property ($fell(internal_bias_supply_en_o) |-> lo_r >= WAKE_FILT)
    else $error("bias stopped before wakes were low long enough");
  a_bias_off_standby: assert property ($fell(internal_bias_supply_en_o) |-> !pre_regulator_en_o)
    else $error("bias stopped outside standby");
  a_prereg_bias: assert property (pre_regulator_en_o |-> internal_bias_supply_en_o)
    else $error("pre-regulator on without bias");
  a_done_prereg: assert property (power_up_done_o |-> pre_regulator_en_o)
    else $error("power-up done without pre-regulator");
endmodule
bind wake_irq_power_sync wips_checker #(.WAKE_FILT(WAKE_FILT), .IRQ_PULSE(IRQ_PULSE)) chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wake_input_one_i(wake_input_one_i),
  .wake_input_two_i(wake_input_two_i), .irq_pulse_out_o(irq_pulse_out_o),
  .irq_pulse_out_oe_o(irq_pulse_out_oe_o), .power_sync_line_o(power_sync_line_o),
  .internal_bias_supply_en_o(internal_bias_supply_en_o), .pre_regulator_en_o(pre_regulator_en_o),
  .power_up_done_o(power_up_done_o)
);
`default_nettype wire

// >>> tb/sync_partner.sv
// Purpose: companion power device on the shared sync line
// Assumes: the line has a pull-up; any party may pull it low
// Notes: releases the line a set number of cycles after power arrives
`timescale 1ns/1ns
`default_nettype none
module sync_partner (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic supply_i,
  input wire logic shutdown_i,
  input wire logic [7:0] ready_delay_i,
  input wire logic dut_oe_i,
  output logic line_o
);
  logic [7:0] up_cnt_r;
  logic hold_low_r;
  // hold the line low until own power-up has finished
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up_cnt_r <= 8'h00;
      hold_low_r <= 1'b1;
    end
    else if (!supply_i || shutdown_i)
    begin
      up_cnt_r <= 8'h00;
      hold_low_r <= 1'b1;
    end
    else if (up_cnt_r < ready_delay_i)
      up_cnt_r <= up_cnt_r + 8'h01;
    else
      hold_low_r <= 1'b0;
  end
  // wired line, the pull-up wins when nobody pulls low
  assign line_o = !(dut_oe_i || hold_low_r);
endmodule
`default_nettype wire

// >>> tb/tb_wake_irq_power_sync.sv
// Purpose: self-checking bench for wake_irq_power_sync
// Assumes: shortened counts, companion model on the sync line
// Notes: table loop over interrupt sources, hand tests for the sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_wake_irq_power_sync;
  import wake_irq_power_sync_pkg::*;
  localparam int WF = 20;
  localparam int IP = 30;
  localparam int SF = 10;
  localparam int OS = 40;
  localparam int OL = 80;
  typedef struct packed {logic [22:0] me; logic [5:0] fe; logic [22:0] mm; logic [5:0] fm; logic ex;} row_t;
  row_t rows[$];
  int failures = 0;
  int samples_checked = 0;
  int n;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, w1 = 1'b0, w2 = 1'b0, twin = 1'b0, shut = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [22:0] mev = 23'h0;
  logic [5:0] fev = 6'h0;
  wire logic [31:0] hrdata;
  wire logic hrdy, resp, irq_oe, s_oe, line, bias, pre, done;
  wake_irq_power_sync #(.WAKE_FILT(WF), .IRQ_PULSE(IP), .SYNC_FILT(SF), .OFF_SHORT(OS), .OFF_LONG(OL)) DUT (
    .ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(resp),
    .wake_input_one_i(w1), .wake_input_two_i(w2), .main_event_i(mev), .fs_event_i(fev),
    .irq_pulse_out_o(), .irq_pulse_out_oe_o(irq_oe), .power_sync_line_i(line), .power_sync_line_o(),
    .power_sync_line_oe_o(s_oe), .internal_bias_supply_en_o(bias), .pre_regulator_en_o(pre),
    .power_up_done_o(done));
  sync_partner twin_dev (.ref_clk_i(clk), .rst_i(rst), .supply_i(pre | twin), .shutdown_i(shut),
    .ready_delay_i(8'h1e), .dut_oe_i(s_oe), .line_o(line));
  always #5 clk = ~clk;
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask
  // one single bus transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    #1;
  endtask
  task automatic fire(input logic [22:0] m, input logic [5:0] f);
    @(posedge clk);
    mev <= m;
    fev <= f;
    @(posedge clk);
    mev <= 23'h0;
    fev <= 6'h0;
    #1;
  endtask
  task automatic pins(input int c, input logic a, input logic b);
    repeat (c) @(posedge clk);
    w1 <= a;
    w2 <= b;
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = bias;
      1: pick = pre;
      2: pick = done;
      default: pick = irq_oe;
    endcase
  endfunction
  // count edges until a watched output reaches a level
  task automatic wait_lvl(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // watchdog: the run needs well under 20000 cycles
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    logic [22:0] me;
    logic [5:0] fe;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 32'h14, 32'hffff_ffff);
    for (int a = 0; a <= 20; a += 4)
    begin
      bus(1'b0, 32'(a), 32'h0);
      check("reset read", 32'h0, rd);
      check("bus response", 32'h0, {31'h0, resp});
    end
    // every source once unmasked and once masked
    for (int i = 0; i < 29; i++)
    begin
      me = (i < 23) ? 23'h1 << i : 23'h0;
      fe = (i < 23) ? 6'h0 : 6'h1 << (i - 23);
      rows.push_back(row_t'({me, fe, ~me, ~fe, 1'b1}));
      rows.push_back(row_t'({me, fe, me, fe, 1'b0}));
    end
    foreach (rows[i])
    begin
      bus(1'b1, MASK_MAIN_OFS, {9'h0, rows[i].mm});
      bus(1'b1, MASK_FS_OFS, {26'h0, rows[i].fm});
      fire(rows[i].me, rows[i].fe);
      wait_lvl(3, 1'b1, 4);
      check("pulse seen", {31'h0, rows[i].ex}, {31'h0, irq_oe});
      wait_lvl(3, 1'b0, 60);
      check_rng("pulse length", rows[i].ex ? IP : 0, rows[i].ex ? IP : 0, n);
      pins(3, 1'b0, 1'b0);
    end
    $display("source table done");
    // two events inside one pulse merge into one follow-up pulse
    bus(1'b1, MASK_MAIN_OFS, 32'h0);
    bus(1'b1, MASK_FS_OFS, 32'h0);
    fire(23'h1, 6'h0);
    fire(23'h2, 6'h0);
    fire(23'h0, 6'h1);
    wait_lvl(3, 1'b0, 60);
    wait_lvl(3, 1'b1, 4);
    wait_lvl(3, 1'b0, 60);
    check_rng("follow-up length", IP, IP, n);
    wait_lvl(3, 1'b1, 40);
    check("no third pulse", 32'h0, {31'h0, irq_oe});
    $display("merge test done");
    // a short wake pulse is filtered out
    pins(1, 1'b1, 1'b0);
    pins(WF / 2, 1'b0, 1'b0);
    pins(3 * WF, 1'b0, 1'b0);
    bus(1'b0, STATUS_OFS, 32'h0);
    check("status after glitch", 32'h0, rd);
    // sync off: start on wake, power down when both wakes drop
    pins(1, 1'b1, 1'b0);
    wait_lvl(0, 1'b1, 3 * WF);
    check_rng("bias delay", WF, WF + 8, n);
    wait_lvl(3, 1'b1, 6);
    check("wake pulse", 32'h1, {31'h0, irq_oe});
    bus(1'b0, STATUS_OFS, 32'h0);
    check("wake level", 32'h1, rd & 32'h3);
    wait_lvl(2, 1'b1, 50);
    check("done", 32'h1, {31'h0, done});
    pins(1, 1'b0, 1'b0);
    wait_lvl(1, 1'b0, 200);
    check_rng("short off delay", WF + OS, WF + OS + 10, n);
    wait_lvl(0, 1'b0, 50);
    check("bias off", 32'h0, {31'h0, bias});
    $display("plain sequence done");
    // external partner holds start-up until it reports power good
    bus(1'b1, CFG_OFS, 32'h7);
    pins(1, 1'b0, 1'b1);
    wait_lvl(1, 1'b1, 3 * WF);
    wait_lvl(2, 1'b1, 80);
    check_rng("wait for partner", 30 + SF, 30 + SF + 12, n);
    bus(1'b1, CTRL_OFS, 32'h1);
    wait_lvl(1, 1'b0, 20);
    check("held for partner", 32'h1, {31'h0, pre});
    @(posedge clk);
    shut <= 1'b1;
    #1;
    wait_lvl(1, 1'b0, 200);
    check_rng("long off delay", SF + OL, SF + OL + 10, n);
    pins(1, 1'b0, 1'b0);
    wait_lvl(0, 1'b0, 100);
    bus(1'b1, CTRL_OFS, 32'h0);
    $display("external partner done");
    // twin device: pre-regulator waits until the twin lets go
    @(posedge clk);
    twin <= 1'b1;
    #1;
    bus(1'b1, CFG_OFS, 32'h1);
    pins(2, 1'b1, 1'b0);
    check("line pulled in standby", 32'h1, {31'h0, s_oe});
    wait_lvl(1, 1'b1, 4 * WF);
    check("waits for twin", 32'h0, {31'h0, pre});
    @(posedge clk);
    shut <= 1'b0;
    #1;
    wait_lvl(1, 1'b1, 80);
    check_rng("start with twin", 30 + SF, 30 + SF + 12, n);
    $display("twin start done");
    // reset in mid-run drops everything
    @(posedge clk);
    rst <= 1'b1;
    #1;
    check("outputs in reset", 32'h0, {28'h0, bias, pre, done, irq_oe});
    pins(3, 1'b0, 1'b0);
    @(posedge clk) rst <= 1'b0;
    bus(1'b0, CFG_OFS, 32'h0);
    check("config after reset", 32'h0, rd);
    $display("reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
